// ---- test_tvm_monitor.sv ----
// Purpose: self-checking bench of the monitor
// Assumes: short temperature slots of 20 and 30 cycles
// Notes:   expected bytes queued from base code and offset
`timescale 1ns/1ps
`default_nettype none
module test_tvm_monitor;
    import tvm_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, cmd_valid, rsp_ready;
    logic diode_fault_pin, pready, pslverr, cmd_ready, rsp_valid, rsp_last;
    logic ack_valid, ack_fcs_bad, adc_start, adc_done;
    logic [7:0]  paddr, rsp_byte;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  adc_sel;
    logic [9:0]  adc_data, base;
    logic [15:0] r;
    logic        e;
    tvm_cmd_s    cmd_in;
    logic [7:0]  q[$];
    int          err_count, check_count;
    tvm_monitor #(.LOCAL_CYC(20), .REMOTE_CYC(30)) dut (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .cmd_valid, .cmd_in, .cmd_ready, .rsp_valid, .rsp_byte,
        .rsp_last, .rsp_ready, .ack_valid, .ack_fcs_bad, .adc_start,
        .adc_sel, .adc_done, .adc_data, .diode_fault_pin);
    tvm_adc_model adc (.pclk, .presetn, .adc_start, .adc_sel, .base,
        .adc_done, .adc_data);
    function automatic logic [15:0] lf(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lf
    function automatic logic [15:0] tmp(input logic [9:0] c);
        return {{2{c[9]}}, c, 4'h0};
    endfunction : tmp
    task automatic stop_test;
        if (err_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [15:0] x, v);
        check_count++;
        if (x !== v)
        begin
            $display("wrong value %s expected %h seen %h", nm, x, v);
            err_count++;
        end
    endtask : chk
    task automatic tmo;
        err_count++;
        stop_test();
    endtask : tmo
    task automatic wait_start;
        int n;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (adc_start !== 1'b1 && n < 6000);
        if (adc_start !== 1'b1)
            tmo();
    endtask : wait_start
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            tmo();
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic pw(input logic [15:0] w);
        q.push_back(w[7:0]);
        q.push_back(w[15:8]);
    endtask : pw
    task automatic cmd(input logic [7:0] c, wl, rl, input logic [15:0] wd,
                       input logic bad);
        int n;
        cmd_in <= '{c, wl, rl, wd};
        cmd_valid <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (cmd_ready !== 1'b1 && n < 99);
        if (cmd_ready !== 1'b1)
            tmo();
        cmd_valid <= 1'b0;
        n = 0;
        while (ack_valid !== 1'b1 && n < 300)
        begin
            @(posedge pclk);
            n++;
            if (rsp_valid === 1'b1 && rsp_ready === 1'b1)
                chk("rsp_byte", 16'(q.pop_front()), 16'(rsp_byte));
            r = lf(r);
            rsp_ready <= r[0] | r[1];
        end
        if (ack_valid !== 1'b1)
            tmo();
        chk("ack_fcs_bad", 16'(bad), 16'(ack_fcs_bad));
        chk("bytes_left", 16'h0000, 16'(q.size()));
    endtask : cmd
    task automatic round(input logic [15:0] off, input logic flt);
        for (int k = 0; k < 8; k++)
            wait_start();
        repeat (6) @(posedge pclk);
        pw(tmp(base));
        cmd(CC_LOCAL, 8'h01, 8'h02, 16'h0000, 1'b0);
        pw(flt ? TEMP_FAULT : tmp(base + 10'h1) + off);
        cmd(CC_REMOTE, 8'h01, 8'h02, 16'h0000, 1'b0);
        pw(tmp(base));
        pw(flt ? TEMP_FAULT : tmp(base + 10'h1) + off);
        cmd(CC_LOCAL, 8'h01, RL_BOTH, 16'h0000, 1'b0);
        for (int i = 0; i < 5; i++)
        begin
            pw(16'(base + 10'(i + 2)) << (i == 0 ? 4 : i == 1 ? 3 : 2));
            cmd(8'(CC_VOLT_FIRST + i), 8'h01, 8'h02, 16'h0000, 1'b0);
        end
        for (int i = 0; i < 5; i++)
            pw(16'(base + 10'(i + 2)) << (i == 0 ? 4 : i == 1 ? 3 : 2));
        repeat (6) q.push_back(8'h00);
        cmd(CC_VOLT_FIRST, 8'h01, RL_ALL_VOLTS, 16'h0000, 1'b0);
        pw(off);
        cmd(CC_OFFSET, 8'h01, 8'h02, 16'h0000, 1'b0);
    endtask : round
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, cmd_valid, diode_fault_pin} = '0;
        {paddr, pwdata, cmd_in} = '0;
        rsp_ready = 1'b1;
        r = 16'h0032;
        base = 10'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", 16'(CTRL_RST), rd[15:0]);
        apb(1'b0, 8'h40, 32'h0);
        chk("pslverr", 16'h0001, 16'(e));
        r = lf(r);
        base <= r[9:0];
        round(16'h0000, 1'b0);
        cmd(CC_OFFSET, 8'h02, 8'h00, 16'h0055, 1'b0);
        cmd(CC_NOP_A, 8'h02, 8'h00, 16'hFFFF, 1'b0);
        cmd(CC_NOP_B, 8'h02, 8'h00, 16'hFFFF, 1'b0);
        cmd(CC_NOP_LO, 8'h02, 8'h00, 16'hFFFF, 1'b0);
        cmd(CC_NOP_HI, 8'h02, 8'h00, 16'hFFFF, 1'b0);
        cmd(CC_RSV_LO, 8'h02, 8'h00, 16'hFFFF, 1'b1);
        cmd(CC_RSV_HI, 8'h02, 8'h00, 16'hFFFF, 1'b1);
        r = lf(r);
        base <= r[9:0];
        round(16'h0055, 1'b0);
        apb(1'b0, REG_OFFSET, 32'h0);
        chk("offset_reg", 16'h0055, rd[15:0]);
        apb(1'b1, REG_CTRL, 32'h3);
        apb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl_low_rate", 16'h0003, rd[15:0]);
        diode_fault_pin <= 1'b1;
        round(16'h0055, 1'b1);
        stop_test();
    end
    initial
    begin
        #10ms;
        err_count++;
        stop_test();
    end
endmodule : test_tvm_monitor
`default_nettype wire

// ---- tvm_adc_model.sv ----
// Purpose: digital side of the shared converter for the bench
// Assumes: code per slot is base plus slot number
// Notes:   data lines show inverted value outside the done pulse
`timescale 1ns/1ps
`default_nettype none
module tvm_adc_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       adc_start,
    input  wire logic [2:0] adc_sel,
    input  wire logic [9:0] base,
    output logic            adc_done,
    output logic [9:0]      adc_data
);
    logic [1:0] cnt_r;
    logic       busy_r;
    logic [9:0] val_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {cnt_r, busy_r, adc_done} <= '0;
            val_r <= '0;
            adc_data <= '1;
        end
        else
        begin
            adc_done <= 1'b0;
            adc_data <= ~val_r;
            cnt_r <= cnt_r + 2'h1;
            if (adc_start)
            begin
                busy_r <= 1'b1;
                cnt_r <= '0;
                val_r <= base + 10'(adc_sel);
            end
            else if (busy_r && cnt_r == 2'h2)
            begin
                busy_r <= 1'b0;
                adc_done <= 1'b1;
                adc_data <= val_r;
            end
        end
    end
endmodule : tvm_adc_model
`default_nettype wire

// ---- tvm_avg.sv ----
// Purpose: sixteen-sample averager for one temperature channel
// Assumes: samples in 1/64 degree units
// Notes:   passes samples straight through when averaging is off
`timescale 1ns/1ps
`default_nettype none
module tvm_avg
    import tvm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        avg_en,
    input  wire logic        in_valid,
    input  wire logic [15:0] in_data,
    output logic             out_valid,
    output logic [15:0]      out_data
);
    logic [19:0] acc_r;
    logic [3:0]  cnt_r;
    logic        ov_r;
    logic [15:0] od_r;
    wire  [19:0] acc_sum = acc_r + {{4{in_data[15]}}, in_data};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_r <= 20'h0;
            cnt_r <= 4'h0;
            ov_r  <= 1'b0;
            od_r  <= 16'h0;
        end
        else
        begin
            ov_r <= 1'b0;
            if (in_valid && !avg_en)
            begin
                ov_r  <= 1'b1;
                od_r  <= in_data;
                cnt_r <= 4'h0;
                acc_r <= 20'h0;
            end
            else if (in_valid)
            begin
                cnt_r <= cnt_r + 4'h1;
                acc_r <= (cnt_r == AVG_LAST) ? 20'h0 : acc_sum;
                if (cnt_r == AVG_LAST)
                begin
                    ov_r <= 1'b1;
                    od_r <= acc_sum[AVG_SHIFT +: 16];
                end
            end
        end
    end

    assign out_valid = ov_r;
    assign out_data  = od_r;

    a_avg_sixteen: assert property (@(posedge pclk) disable iff (!presetn)
        in_valid && avg_en && $past(avg_en) && cnt_r != AVG_LAST
        |=> !ov_r)
        else $error("average issued before sixteen samples");
endmodule : tvm_avg
`default_nettype wire

// ---- tvm_conv_seq.sv ----
// Purpose: round-robin conversion slot sequencer
// Assumes: slot lengths given in pclk cycles
// Notes:   slot 0 local, 1 remote, 2..6 voltage channels
`timescale 1ns/1ps
`default_nettype none
module tvm_conv_seq
    import tvm_pkg::*;
#(
    parameter int unsigned LOCAL_CYC  = LOCAL_CONV_CYC,
    parameter int unsigned REMOTE_CYC = REMOTE_CONV_CYC
)(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       enable,
    output logic [2:0]      slot,
    output logic            adc_start,
    output logic            slot_end
);
    logic [19:0] timer_r;
    logic [2:0]  slot_r;
    logic        start_r;
    wire  [2:0]  slot_nxt = (slot_r == SLOT_LAST) ? SLOT_LOCAL : slot_r + 3'h1;
    wire  [19:0] len_nxt  = (slot_nxt == SLOT_LOCAL)  ? 20'(LOCAL_CYC - 1) :
                            (slot_nxt == SLOT_REMOTE) ? 20'(REMOTE_CYC - 1) :
                            20'(VOLT_CONV_CYC - 1);
    wire         expire   = enable && (timer_r == 20'h0);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer_r <= 20'h0;
            slot_r  <= SLOT_LAST;
            start_r <= 1'b0;
        end
        else
        begin
            start_r <= expire;
            if (expire)
            begin
                slot_r  <= slot_nxt;
                timer_r <= len_nxt;
            end
            else if (enable)
                timer_r <= timer_r - 20'h1;
        end
    end

    assign slot      = slot_r;
    assign adc_start = start_r;
    assign slot_end  = expire;

    a_slot_order: assert property (@(posedge pclk) disable iff (!presetn)
        expire && slot_r == SLOT_LOCAL |=> slot_r == SLOT_REMOTE)
        else $error("remote slot does not follow local slot");
endmodule : tvm_conv_seq
`default_nettype wire

// ---- tvm_monitor.sv ----
// Purpose: command responder and conversion control of the monitor
// Assumes: framing layer outside; converter digital side on pclk
// Notes:   results held per channel so reads never wait
// Operation
// - remote temperature read returns 16-bit value, low byte first
// - open or shorted remote diode reports 0x8000
// - both-temperatures read returns local word then remote word
// - host writes offset low byte first; stored as remote correction
// - offset read returns offset in use, low byte first
// - only code 0xE0 accepts written data; others keep contents
// - writes to 0x02, 0x09, 0x15..0xDF get valid check, no effect
// - writes to 0xE2..0xEE get invalid check, nothing stored
// - all inputs share one 10-bit successive-approximation converter
// - voltage full scale 16 V, 8 V, or 4 V per channel
// - codes 0x10..0x14 pick the five voltages, low byte first
// - code 0x10 with length 0x10 returns all voltages in order
// - voltages are 16-bit counts of 1/1024 V
// - temperatures converted round robin: local 12 ms, remote 38 ms
// - at low rate each temperature averages 16 measurements
// - code 0x00 with length 0x04 returns both temperatures
// - programmed offset added to each remote result before report
// - code 0x01 reads remote, 0x00 with two bytes reads local
// - temperatures are 16-bit values in 1/64 degree steps
`timescale 1ns/1ps
`default_nettype none
module tvm_monitor
    import tvm_pkg::*;
#(
    parameter int unsigned LOCAL_CYC  = LOCAL_CONV_CYC,
    parameter int unsigned REMOTE_CYC = REMOTE_CONV_CYC
)(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             cmd_valid,
    input  wire tvm_pkg::tvm_cmd_s cmd_in,
    output logic                  cmd_ready,
    output logic                  rsp_valid,
    output logic [7:0]            rsp_byte,
    output logic                  rsp_last,
    input  wire logic             rsp_ready,
    output logic                  ack_valid,
    output logic                  ack_fcs_bad,
    output logic                  adc_start,
    output logic [2:0]            adc_sel,
    input  wire logic             adc_done,
    input  wire logic [9:0]       adc_data,
    input  wire logic             diode_fault_pin
);
    import tvm_pkg::*;

    // temperature code in quarter degrees to 1/64 degree
    function automatic logic [15:0] temp_scale(input logic [9:0] c);
        temp_scale = {{2{c[9]}}, c, 4'h0};
    endfunction : temp_scale

    // converter code to 1/1024 V counts per channel full scale
    function automatic logic [15:0] volt_scale(input logic [9:0] c,
                                               input logic [2:0] ch);
        case (ch)
            3'h0:    volt_scale = {2'h0, c, 4'h0};
            3'h1:    volt_scale = {3'h0, c, 3'h0};
            default: volt_scale = {4'h0, c, 2'h0};
        endcase
    endfunction : volt_scale

    function automatic logic in_range(input logic [7:0] v,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction : in_range

    tvm_state_e  state_r;
    tvm_state_e  state_nxt;
    tvm_cmd_s    cmd_r;
    logic [7:0]  idx_r;
    logic        cmd_ready_r;
    logic        rsp_valid_r;
    logic [7:0]  rsp_byte_r;
    logic        rsp_last_r;
    logic        ack_valid_r;
    logic        ack_fcs_bad_r;
    logic [15:0] offset_r;
    logic [15:0] local_r;
    logic [15:0] remote_r;
    logic [15:0] volt_r [5];
    logic [9:0]  sample_r;
    logic [1:0]  ctrl_r;
    logic        fault_m_r;
    logic        fault_s_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [2:0]  slot;
    logic        conv_start;
    logic        slot_end;
    logic        loc_valid;
    logic [15:0] loc_avg;
    logic        rem_valid;
    logic [15:0] rem_avg;

    // conversion sequencing
    tvm_conv_seq #(
        .LOCAL_CYC  (LOCAL_CYC),
        .REMOTE_CYC (REMOTE_CYC)
    ) u_seq (
        .pclk      (pclk),
        .presetn   (presetn),
        .enable    (ctrl_r[CTRL_CONV_EN]),
        .slot      (slot),
        .adc_start (conv_start),
        .slot_end  (slot_end)
    );

    wire loc_in = slot_end && slot == SLOT_LOCAL;
    wire rem_in = slot_end && slot == SLOT_REMOTE;
    wire vlt_in = slot_end && slot > SLOT_REMOTE;
    wire [2:0] vch = slot - 3'h2;

    tvm_avg u_avg_local (
        .pclk      (pclk),
        .presetn   (presetn),
        .avg_en    (ctrl_r[CTRL_LOW_RATE]),
        .in_valid  (loc_in),
        .in_data   (temp_scale(sample_r)),
        .out_valid (loc_valid),
        .out_data  (loc_avg)
    );

    tvm_avg u_avg_remote (
        .pclk      (pclk),
        .presetn   (presetn),
        .avg_en    (ctrl_r[CTRL_LOW_RATE]),
        .in_valid  (rem_in),
        .in_data   (temp_scale(sample_r)),
        .out_valid (rem_valid),
        .out_data  (rem_avg)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sample_r <= 10'h000;
        else if (adc_done)
            sample_r <= adc_data;
    end

    // fault pin synchroniser
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault_m_r <= 1'b0;
            fault_s_r <= 1'b0;
        end
        else
        begin
            fault_m_r <= diode_fault_pin;
            fault_s_r <= fault_m_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            local_r  <= 16'h0000;
            remote_r <= 16'h0000;
        end
        else
        begin
            if (loc_valid)
                local_r <= loc_avg;
            if (rem_valid)
                remote_r <= rem_avg + offset_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 5; i++)
                volt_r[i] <= 16'h0000;
        end
        else if (vlt_in)
            volt_r[vch] <= volt_scale(sample_r, vch);
    end

    wire [15:0] remote_rpt = fault_s_r ? TEMP_FAULT : remote_r;

    // command decode
    wire        take      = cmd_valid && cmd_ready_r;
    wire        is_wr     = cmd_in.wlen >= WL_WRITE_MIN;
    wire        wr_offset = take && is_wr && cmd_in.code == CC_OFFSET;
    wire        wr_rsv    = take && is_wr
                            && in_range(cmd_in.code, CC_RSV_LO, CC_RSV_HI);
    wire        wr_other  = take && is_wr && !wr_offset && !wr_rsv;
    wire        rd_take   = take && !is_wr && cmd_in.rlen != 8'h00;
    wire        nil_take  = take && !is_wr && cmd_in.rlen == 8'h00;
    tvm_cmd_s   sel_cmd;
    assign sel_cmd = (state_r == ST_IDLE) ? cmd_in : cmd_r;
    wire [7:0]  pick_idx  = (state_r == ST_IDLE) ? 8'h00 : idx_r + 8'h01;
    wire [6:0]  pick_word = pick_idx[7:1];
    wire [7:0]  vsel_code = (sel_cmd.code == CC_VOLT_FIRST
                             && sel_cmd.rlen == RL_ALL_VOLTS)
                            ? 8'(CC_VOLT_FIRST + {1'b0, pick_word})
                            : sel_cmd.code;
    wire [7:0]  vidx      = vsel_code - CC_VOLT_FIRST;
    wire        vok       = in_range(vsel_code, CC_VOLT_FIRST, CC_VOLT_LAST);

    wire [15:0] pick_val  =
        (sel_cmd.code == CC_LOCAL && sel_cmd.rlen == RL_BOTH)
            ? (pick_word == 7'h0 ? local_r
               : pick_word == 7'h1 ? remote_rpt : 16'h0000) :
        (sel_cmd.code == CC_LOCAL && pick_word == 7'h0) ? local_r :
        (sel_cmd.code == CC_REMOTE && pick_word == 7'h0) ? remote_rpt :
        (sel_cmd.code == CC_OFFSET && pick_word == 7'h0) ? offset_r :
        (vok && (sel_cmd.rlen == RL_ALL_VOLTS || pick_word == 7'h0))
            ? volt_r[vidx[2:0]] : 16'h0000;
    wire [7:0]  pick_byte = pick_idx[0] ? pick_val[15:8] : pick_val[7:0];
    wire        pick_last = pick_idx == sel_cmd.rlen - 8'h01;
    wire        rsp_fire  = rsp_valid_r && rsp_ready;

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:
                if (rd_take)
                    state_nxt = ST_SEND;
                else if (take)
                    state_nxt = ST_ACK;
            ST_SEND:
                if (rsp_fire && rsp_last_r)
                    state_nxt = ST_ACK;
            ST_ACK:
                state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r     <= ST_IDLE;
            cmd_r       <= '0;
            idx_r       <= 8'h00;
            cmd_ready_r <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            cmd_ready_r <= state_nxt == ST_IDLE && state_r != ST_ACK;
            if (take)
                cmd_r <= cmd_in;
            if (rd_take)
                idx_r <= 8'h00;
            else if (rsp_fire)
                idx_r <= pick_idx;
        end
    end

    // response byte stream
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rsp_valid_r <= 1'b0;
            rsp_byte_r  <= 8'h00;
            rsp_last_r  <= 1'b0;
        end
        else if (rd_take || (rsp_fire && !rsp_last_r))
        begin
            rsp_valid_r <= 1'b1;
            rsp_byte_r  <= pick_byte;
            rsp_last_r  <= pick_last;
        end
        else if (rsp_fire)
        begin
            rsp_valid_r <= 1'b0;
            rsp_last_r  <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ack_valid_r   <= 1'b0;
            ack_fcs_bad_r <= 1'b0;
        end
        else
        begin
            ack_valid_r   <= (take && !rd_take) || (rsp_fire && rsp_last_r);
            ack_fcs_bad_r <= wr_rsv;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            offset_r <= OFFSET_RST;
        else if (wr_offset)
            offset_r <= cmd_in.wdata;
    end

    // apb slave, one wait state
    wire        apb_acc  = psel && penable && !pready_r;
    wire        apb_map  = paddr == REG_CTRL || paddr == REG_STATUS
                           || paddr == REG_OFFSET || paddr == REG_LOCAL
                           || paddr == REG_REMOTE;
    wire [31:0] apb_rd   =
        paddr == REG_CTRL   ? {30'h0, ctrl_r} :
        paddr == REG_STATUS ? {24'h0, state_r == ST_IDLE, slot,
                               3'h0, fault_s_r} :
        paddr == REG_OFFSET ? {16'h0, offset_r} :
        paddr == REG_LOCAL  ? {16'h0, local_r} :
        paddr == REG_REMOTE ? {16'h0, remote_rpt} : 32'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
            ctrl_r    <= CTRL_RST;
        end
        else
        begin
            pready_r  <= apb_acc;
            pslverr_r <= apb_acc && !apb_map;
            prdata_r  <= (apb_acc && !pwrite) ? apb_rd : 32'h0;
            if (pready_r && psel && penable && pwrite && paddr == REG_CTRL)
                ctrl_r <= pwdata[1:0];
        end
    end

    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign cmd_ready   = cmd_ready_r;
    assign rsp_valid   = rsp_valid_r;
    assign rsp_byte    = rsp_byte_r;
    assign rsp_last    = rsp_last_r;
    assign ack_valid   = ack_valid_r;
    assign ack_fcs_bad = ack_fcs_bad_r;
    assign adc_start   = conv_start;
    assign adc_sel     = slot;

    sequence s_ack_good;
        ack_valid_r && !ack_fcs_bad_r;
    endsequence
    sequence s_ack_bad;
        ack_valid_r && ack_fcs_bad_r;
    endsequence

    a_remote_low: assert property (@(posedge pclk) disable iff (!presetn)
        rd_take && cmd_in.code == CC_REMOTE && !fault_s_r && !rem_valid
        |=> rsp_byte_r == remote_r[7:0])
        else $error("remote read does not start with low byte");

    a_fault_code: assert property (@(posedge pclk) disable iff (!presetn)
        rd_take && cmd_in.code == CC_REMOTE && fault_s_r
        |=> rsp_byte_r == 8'h00)
        else $error("faulty diode not reported as 0x8000");

    a_both_order: assert property (@(posedge pclk) disable iff (!presetn)
        rd_take && cmd_in.code == CC_LOCAL && cmd_in.rlen == RL_BOTH
        && !loc_valid |=> rsp_byte_r == local_r[7:0])
        else $error("both-temperature read not local first");

    a_offset_keep: assert property (@(posedge pclk) disable iff (!presetn)
        wr_offset |=> offset_r == $past(cmd_in.wdata))
        else $error("offset write not stored");

    a_nop_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_other |=> s_ack_good and $stable(offset_r))
        else $error("ignored write changed state or bad check");

    a_rsv_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_rsv |=> s_ack_bad and $stable(offset_r))
        else $error("reserved write not refused");

    a_volt_order: assert property (@(posedge pclk) disable iff (!presetn)
        rd_take && cmd_in.code == CC_VOLT_FIRST
        && cmd_in.rlen == RL_ALL_VOLTS && !vlt_in
        |=> rsp_byte_r == volt_r[0][7:0])
        else $error("all-voltage read not starting at first channel");

    a_read_end: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_fire && rsp_last_r |=> s_ack_good ##2 cmd_ready_r)
        else $error("read did not close with good check");
endmodule : tvm_monitor
`default_nettype wire

// ---- tvm_pkg.sv ----
// Purpose: shared constants and types of the temperature and voltage monitor
// Assumes: 10 MHz pclk, 10-bit converter, APB register access
// Notes:   command codes, timing, register map and carriers
package tvm_pkg;
    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned LOCAL_CONV_MS  = 12;
    localparam int unsigned REMOTE_CONV_MS = 38;
    localparam int unsigned VOLT_CONV_US   = 500;
    localparam int unsigned LOCAL_CONV_CYC = LOCAL_CONV_MS * (CLK_HZ / 1000);
    localparam int unsigned REMOTE_CONV_CYC = REMOTE_CONV_MS * (CLK_HZ / 1000);
    localparam int unsigned VOLT_CONV_CYC  = VOLT_CONV_US * (CLK_HZ / 1000000);
    localparam int unsigned ADC_W          = 10;
    localparam int unsigned AVG_SHIFT      = 4;
    localparam logic [3:0]  AVG_LAST       = 4'hF;
    localparam logic [2:0]  SLOT_LOCAL     = 3'h0;
    localparam logic [2:0]  SLOT_REMOTE    = 3'h1;
    localparam logic [2:0]  SLOT_LAST      = 3'h6;
    localparam logic [7:0]  CC_LOCAL       = 8'h00;
    localparam logic [7:0]  CC_REMOTE      = 8'h01;
    localparam logic [7:0]  CC_NOP_A       = 8'h02;
    localparam logic [7:0]  CC_NOP_B       = 8'h09;
    localparam logic [7:0]  CC_VOLT_FIRST  = 8'h10;
    localparam logic [7:0]  CC_VOLT_LAST   = 8'h14;
    localparam logic [7:0]  CC_NOP_LO      = 8'h15;
    localparam logic [7:0]  CC_NOP_HI      = 8'hDF;
    localparam logic [7:0]  CC_OFFSET      = 8'hE0;
    localparam logic [7:0]  CC_RSV_LO      = 8'hE2;
    localparam logic [7:0]  CC_RSV_HI      = 8'hEE;
    localparam logic [7:0]  RL_BOTH        = 8'h04;
    localparam logic [7:0]  RL_ALL_VOLTS   = 8'h10;
    localparam logic [7:0]  WL_WRITE_MIN   = 8'h02;
    localparam logic [15:0] TEMP_FAULT     = 16'h8000;
    localparam logic [15:0] OFFSET_RST     = 16'h0000;
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_STATUS     = 8'h04;
    localparam logic [7:0]  REG_OFFSET     = 8'h08;
    localparam logic [7:0]  REG_LOCAL      = 8'h0C;
    localparam logic [7:0]  REG_REMOTE     = 8'h10;
    localparam logic [1:0]  CTRL_RST       = 2'h1;
    localparam int unsigned CTRL_CONV_EN   = 0;
    localparam int unsigned CTRL_LOW_RATE  = 1;
    typedef struct packed {
        logic [7:0]  code;
        logic [7:0]  wlen;
        logic [7:0]  rlen;
        logic [15:0] wdata;
    } tvm_cmd_s;
    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_ACK} tvm_state_e;
endpackage : tvm_pkg
